// ### rtl/psc_pkg.sv
/*
 Constants for the PHY special control and port 1 control register slice.
 Assumes a 16-bit host register port with word offsets and a synchronous write strobe.
*/
package psc_pkg;
   localparam logic [7:0] PHY1_SPECIAL_CONTROL_STATUS = 8'h66;
   localparam logic [7:0] PHY2_SPECIAL_CONTROL_STATUS = 8'h6A;
   localparam logic [7:0] PORT1_CONTROL_WORD_ONE = 8'h6C;
   localparam logic [7:0] PORT1_SPECIAL_CTRL_REG = 8'h76;
   localparam logic [7:0] PORT2_SPECIAL_CTRL_REG = 8'h86;
   localparam int POL_BIT = 5;
   localparam int MDIX_BIT = 4;
   localparam int FORCE_BIT = 3;
   localparam int EEE_BIT = 2;
   localparam int LOOP_BIT = 1;
   localparam int SR_POL_BIT = 13;
   localparam int SR_MDIX_BIT = 7;
   localparam int SC_FORCE_BIT = 11;
   localparam int SC_LOOP_BIT = 9;
   localparam int LED_LSB = 12;
   localparam int LED_MSB = 14;
   localparam int SAF2_BIT = 11;
   localparam logic RST_FORCE = 1'h0;
   localparam logic RST_EEE_DIS = 1'h1;
   localparam logic RST_LOOP = 1'h0;
   localparam logic [2:0] RST_LED = 3'h0;
   localparam logic RST_SAF2 = 1'h0;
endpackage

// ### rtl/psc_regs.sv
/*
 Register slice: PHY special control/status words and port 1 control upper bits.
 Assumes status bits from the PHYs are synchronous to CORE_CLK_I.
*/
`timescale 1ns/10ps
module psc_regs (
   input wire logic CORE_CLK_I,
   input wire logic RSTN_I,
   input wire logic [7:0] ADDR_I,
   input wire logic WR_I,
   input wire logic [15:0] WDATA_I,
   output logic [15:0] RDATA_O,
   input wire logic [1:0] POL_REV_I,
   input wire logic [1:0] MDIX_I,
   output logic [1:0] FORCE_LINK_O,
   output logic [1:0] TEN_LOW_ENERGY_DIS_O,
   output logic [1:0] REMOTE_LOOP_O,
   input wire logic [1:0] LED_NORMAL_I,
   output logic [1:0] LED_O,
   output logic SAF2_EN_O
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [1:0] force_q;
   logic [1:0] force_d;
   logic [1:0] eee_q;
   logic [1:0] eee_d;
   logic [1:0] loop_q;
   logic [1:0] loop_d;
   logic [2:0] led_q;
   logic [2:0] led_d;
   logic saf2_q;
   logic saf2_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic [1:0] phy_wr_hit;
   logic [1:0] sc_wr_hit;
   logic pcw_wr_hit;
   logic [1:0] led_drive;

   // ----------------------------------------
   // Decoding and packing
   // ----------------------------------------
   function automatic logic [7:0] phy_addr(input logic port);
      logic [7:0] a;
      a = psc_pkg::PHY1_SPECIAL_CONTROL_STATUS;
      if (port) begin
         a = psc_pkg::PHY2_SPECIAL_CONTROL_STATUS;
      end
      return a;
   endfunction

   function automatic logic [7:0] sc_addr(input logic port);
      logic [7:0] a;
      a = psc_pkg::PORT1_SPECIAL_CTRL_REG;
      if (port) begin
         a = psc_pkg::PORT2_SPECIAL_CTRL_REG;
      end
      return a;
   endfunction

   function automatic logic [15:0] phy_word(input logic p, input logic m, input logic f,
                                             input logic e, input logic l);
      logic [15:0] w;
      w = 16'h0000;
      w[psc_pkg::POL_BIT] = p;
      w[psc_pkg::MDIX_BIT] = m;
      w[psc_pkg::FORCE_BIT] = f;
      w[psc_pkg::EEE_BIT] = e;
      w[psc_pkg::LOOP_BIT] = l;
      return w;
   endfunction

   function automatic logic [15:0] sc_word(input logic f, input logic l);
      logic [15:0] w;
      w = 16'h0000;
      w[psc_pkg::SC_FORCE_BIT] = f;
      w[psc_pkg::SC_LOOP_BIT] = l;
      return w;
   endfunction

   function automatic logic [15:0] pcw_word(input logic [2:0] led, input logic saf2);
      logic [15:0] w;
      w = 16'h0000;
      w[psc_pkg::LED_MSB:psc_pkg::LED_LSB] = led;
      w[psc_pkg::SAF2_BIT] = saf2;
      return w;
   endfunction

   function automatic logic [1:0] led_pins(input logic [2:0] ctrl, input logic [1:0] normal);
      logic [1:0] pins;
      pins = normal;
      if (ctrl[2]) begin
         pins = ctrl[1:0];
      end
      return pins;
   endfunction

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   always_comb begin
      phy_wr_hit = 2'h0;
      sc_wr_hit = 2'h0;
      pcw_wr_hit = 1'h0;
      if (WR_I) begin
         phy_wr_hit[0] = (ADDR_I == phy_addr(1'h0));
         phy_wr_hit[1] = (ADDR_I == phy_addr(1'h1));
         sc_wr_hit[0] = (ADDR_I == sc_addr(1'h0));
         sc_wr_hit[1] = (ADDR_I == sc_addr(1'h1));
         pcw_wr_hit = (ADDR_I == psc_pkg::PORT1_CONTROL_WORD_ONE);
      end
   end

   // ----------------------------------------
   // PHY control fields
   // ----------------------------------------
   // Port special control writes reach the same storage
   always_comb begin
      force_d = force_q;
      eee_d = eee_q;
      loop_d = loop_q;
      for (int i = 0; i < 2; i++) begin
         if (phy_wr_hit[i]) begin
            force_d[i] = WDATA_I[psc_pkg::FORCE_BIT];
            eee_d[i] = WDATA_I[psc_pkg::EEE_BIT];
            loop_d[i] = WDATA_I[psc_pkg::LOOP_BIT];
         end
         if (sc_wr_hit[i]) begin
            force_d[i] = WDATA_I[psc_pkg::SC_FORCE_BIT];
            loop_d[i] = WDATA_I[psc_pkg::SC_LOOP_BIT];
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         force_q <= {2{psc_pkg::RST_FORCE}};
         eee_q <= {2{psc_pkg::RST_EEE_DIS}};
         loop_q <= {2{psc_pkg::RST_LOOP}};
      end else begin
         force_q <= force_d;
         eee_q <= eee_d;
         loop_q <= loop_d;
      end
   end

   // ----------------------------------------
   // Port 1 control fields
   // ----------------------------------------
   always_comb begin
      led_d = led_q;
      saf2_d = saf2_q;
      if (pcw_wr_hit) begin
         led_d = WDATA_I[psc_pkg::LED_MSB:psc_pkg::LED_LSB];
         saf2_d = WDATA_I[psc_pkg::SAF2_BIT];
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         led_q <= psc_pkg::RST_LED;
         saf2_q <= psc_pkg::RST_SAF2;
      end else begin
         led_q <= led_d;
         saf2_q <= saf2_d;
      end
   end

   // ----------------------------------------
   // LED drive
   // ----------------------------------------
   always_comb begin
      led_drive = led_pins(led_q, LED_NORMAL_I);
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Unmapped offsets read as zero
   always_comb begin
      rdata_d = 16'h0000;
      unique case (ADDR_I)
         psc_pkg::PHY1_SPECIAL_CONTROL_STATUS: begin
            rdata_d = phy_word(POL_REV_I[0], MDIX_I[0], force_q[0], eee_q[0], loop_q[0]);
         end
         psc_pkg::PHY2_SPECIAL_CONTROL_STATUS: begin
            rdata_d = phy_word(POL_REV_I[1], MDIX_I[1], force_q[1], eee_q[1], loop_q[1]);
         end
         psc_pkg::PORT1_SPECIAL_CTRL_REG: begin
            rdata_d = sc_word(force_q[0], loop_q[0]);
         end
         psc_pkg::PORT2_SPECIAL_CTRL_REG: begin
            rdata_d = sc_word(force_q[1], loop_q[1]);
         end
         psc_pkg::PORT1_CONTROL_WORD_ONE: begin
            rdata_d = pcw_word(led_q, saf2_q);
         end
         default: begin
            rdata_d = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign RDATA_O = rdata_q;
   assign FORCE_LINK_O = force_q;
   assign TEN_LOW_ENERGY_DIS_O = eee_q;
   assign REMOTE_LOOP_O = loop_q;
   assign SAF2_EN_O = saf2_q;
   assign LED_O = led_drive;
endmodule

// ### bench/psc_regs_sva.sv
/* Checker for the psc_regs register slice.
 Sees only the top ports; bound to every psc_regs instance. */
`timescale 1ns/10ps
module psc_regs_sva (
   input wire logic CORE_CLK_I,
   input wire logic RSTN_I,
   input wire logic [7:0] ADDR_I,
   input wire logic WR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic [15:0] RDATA_O,
   input wire logic [1:0] POL_REV_I,
   input wire logic [1:0] MDIX_I,
   input wire logic [1:0] FORCE_LINK_O,
   input wire logic [1:0] TEN_LOW_ENERGY_DIS_O,
   input wire logic [1:0] REMOTE_LOOP_O,
   input wire logic [1:0] LED_NORMAL_I,
   input wire logic [1:0] LED_O,
   input wire logic SAF2_EN_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);
   sequence wr_at(a);
      WR_I && ADDR_I == a;
   endsequence
   a_phy1_status: assert property (ADDR_I == 8'h66 |=>
      RDATA_O[5:4] == {$past(POL_REV_I[0]), $past(MDIX_I[0])})
      else $error("phy1 status bits wrong");
   a_phy2_status: assert property (ADDR_I == 8'h6A |=>
      RDATA_O[5:4] == {$past(POL_REV_I[1]), $past(MDIX_I[1])})
      else $error("phy2 status bits wrong");
   a_phy1_write: assert property (wr_at(8'h66) |=>
      {FORCE_LINK_O[0], TEN_LOW_ENERGY_DIS_O[0], REMOTE_LOOP_O[0]} == $past(WDATA_I[3:1]))
      else $error("phy1 control not taken");
   a_phy2_write: assert property (wr_at(8'h6A) |=>
      {FORCE_LINK_O[1], TEN_LOW_ENERGY_DIS_O[1], REMOTE_LOOP_O[1]} == $past(WDATA_I[3:1]))
      else $error("phy2 control not taken");
   a_shared_store: assert property (wr_at(8'h76) |=>
      {FORCE_LINK_O[0], REMOTE_LOOP_O[0]} == {$past(WDATA_I[11]), $past(WDATA_I[9])})
      else $error("shared storage not updated");
   a_port2_shared: assert property (wr_at(8'h86) |=>
      {FORCE_LINK_O[1], REMOTE_LOOP_O[1]} == {$past(WDATA_I[11]), $past(WDATA_I[9])})
      else $error("port2 shared storage not updated");
   a_filter_write: assert property (wr_at(8'h6C) |=> SAF2_EN_O == $past(WDATA_I[11]))
      else $error("filter enable not taken");
   a_led_mux: assert property (ADDR_I == 8'h6C && !WR_I |=>
      (RDATA_O[14] ? LED_O == RDATA_O[13:12] : LED_O == LED_NORMAL_I))
      else $error("led override wrong");
   a_reserved_zero: assert property (ADDR_I inside {8'h66, 8'h6A} |=>
      RDATA_O[15:6] == 10'h000 && !RDATA_O[0])
      else $error("reserved bits not zero");
   a_no_write: assert property (!WR_I |=>
      $stable(FORCE_LINK_O) && $stable(SAF2_EN_O) && $stable(REMOTE_LOOP_O))
      else $error("control changed without write");
endmodule
bind psc_regs psc_regs_sva i_psc_regs_sva(.*);

// ### bench/psc_regs_test.sv
/* Self-checking bench for psc_regs.
 Drives all inputs at the falling edge of a 50 ns clock. */
`timescale 1ns/10ps
module psc_regs_test;
   logic CORE_CLK_I = 1'b0, RSTN_I = 1'b0, WR_I = 1'b0;
   logic [7:0] ADDR_I = 8'h00;
   logic [15:0] WDATA_I = 16'h0000, RDATA_O;
   logic [1:0] POL_REV_I = 2'h2, MDIX_I = 2'h1, LED_NORMAL_I = 2'h2;
   logic [1:0] FORCE_LINK_O, TEN_LOW_ENERGY_DIS_O, REMOTE_LOOP_O, LED_O;
   logic SAF2_EN_O;
   int error_cnt = 0, checks = 0;
   psc_regs i_psc_regs(.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .WDATA_I(WDATA_I),
      .RDATA_O(RDATA_O), .POL_REV_I(POL_REV_I), .MDIX_I(MDIX_I), .FORCE_LINK_O(FORCE_LINK_O),
      .TEN_LOW_ENERGY_DIS_O(TEN_LOW_ENERGY_DIS_O), .REMOTE_LOOP_O(REMOTE_LOOP_O), .LED_NORMAL_I(LED_NORMAL_I),
      .LED_O(LED_O), .SAF2_EN_O(SAF2_EN_O));
   initial forever #25 CORE_CLK_I = ~CORE_CLK_I;
   task chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge CORE_CLK_I) {ADDR_I, WDATA_I, WR_I} = {a, d, 1'b1};
      @(negedge CORE_CLK_I) WR_I = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge CORE_CLK_I) ADDR_I = a;
      @(negedge CORE_CLK_I) chk(RDATA_O, e);
   endtask
   task conclude;
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge CORE_CLK_I);
      RSTN_I = 1'b1;
      rd(8'h66, 16'h0014);
      rd(8'h6A, 16'h0024);
      chk({11'h000, SAF2_EN_O, FORCE_LINK_O, REMOTE_LOOP_O}, 16'h0000);
      wr(8'h66, 16'hFFFF);
      rd(8'h66, 16'h001E);
      wr(8'h6A, 16'h0000);
      chk({10'h000, FORCE_LINK_O, TEN_LOW_ENERGY_DIS_O, REMOTE_LOOP_O}, 16'h0015);
      {POL_REV_I, MDIX_I} = {2'h1, 2'h2};
      wr(8'h76, 16'h0000);
      rd(8'h66, 16'h0024);
      wr(8'h86, 16'hFFFF);
      rd(8'h86, 16'h0A00);
      rd(8'h6A, 16'h001A);
      for (int v = 0; v < 8; v++) begin
         LED_NORMAL_I = ~v[1:0];
         wr(8'h6C, {1'b1, v[2:0], 12'hFFF});
         rd(8'h6C, {1'b0, v[2:0], 12'h800});
         chk({14'h0000, LED_O}, {14'h0000, v[2] ? v[1:0] : LED_NORMAL_I});
      end
      wr(8'h6C, 16'h0000);
      chk({15'h0000, SAF2_EN_O}, 16'h0000);
      rd(8'h00, 16'h0000);
      conclude();
   end
endmodule
